// ===== sppm_codec_model.sv
// Bank of four slave codecs on the serial pins, recording frame syncs.
// Assumes syncs are synchronous to clk; the model itself drives the bit clock pin.
`timescale 1ns/1ps
module sppm_codec_model (
   // Clock and reset
   input wire logic   clk,
   input wire logic   reset_n,
   // Frame syncs of channels one to four
   input wire logic [3:0] syncs,
   // Pins driven by the codecs
   output logic        shiftClkPin,
   output logic        rcvDrive,
   // Observations
   output logic [15:0] riseAt [4],
   output logic [15:0] period1,
   output logic [7:0]  syncCnt [4]
);
   logic [15:0] cyc_ff;
   logic [3:0]  prev_ff;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cyc_ff <= 16'h0000;
         prev_ff <= 4'h0;
         shiftClkPin <= 1'b0;
         rcvDrive <= 1'b0;
         period1 <= 16'h0000;
         for (int k = 0; k < 4; k++) begin
            riseAt[k] <= 16'h0000;
            syncCnt[k] <= 8'h00;
         end
      end else begin
         cyc_ff <= cyc_ff + 16'h0001;
         prev_ff <= syncs;
         // Pattern changes every cycle so a stale level never passes as data
         rcvDrive <= ~rcvDrive;
         // Continuous bit clock, so pin-clocked counting can be measured
         shiftClkPin <= ~shiftClkPin;
         if (syncs[0] && !prev_ff[0]) period1 <= cyc_ff - riseAt[0];
         for (int k = 0; k < 4; k++) begin
            if (syncs[k] && !prev_ff[k]) begin
               riseAt[k] <= cyc_ff;
               syncCnt[k] <= syncCnt[k] + 8'h01;
            end
         end
      end
   end
endmodule // sppm_codec_model

// ===== sppm_consts.svh
// Constants for the serial port prescaler and multichannel block.
// Assumes a 32-bit APB slave and one 100 MHz core clock.
//
// What this block does
// - Multichannel bit 3 off by default; on uses only prescaled transmit sync.
// - Multichannel routes transmit sync and clock inside; receive pins output syncs.
// - Multichannel puts fourth channel sync on general io zero, not GPIO.
// - Counter-interrupt bit 2 makes counter zero raise transmit interrupt instead.
// - Counter-halt bit 1 clear lets counter count; set stops it.
// - Counter-mode bit 0 chains both prescalers into one 16-bit counter.
// - Counter clocks from core clock or shift-clock pin per source select.
// - Shift clock is core clock over two times prescale plus one.
// - Shift prescale resets to zero, giving half core clock rate.
// - Shift prescaler counts down, readable, runs only while prescaler enable set, except in counter mode.
// - Count writes fill buffers; counters load them when prescaler enable sets.
// - At zero each prescaler reloads its buffer; no clock while enable clear.
// - Frame-sync prescaler divides shift clock by two times prescale plus one.
// - Frame-sync zero flag sets at every zero; writing one clears it.
// - Channel select picks one to four channels, each sync spaced after last bit.
// - In counter mode zero sets flag, reloads start value, keeps counting.
`ifndef SPPM_CONSTS_SVH
`define SPPM_CONSTS_SVH
// Register indices; byte address is four times the index
`define SPPM_IDX_MC      16'hFFF3
`define SPPM_IDX_CT      16'hFFFB
`define SPPM_IDX_ST      16'hFFF6
`define SPPM_IDX_ISTS    16'hFFF8
`define SPPM_IDX_ICLR    16'hFFF9
`define SPPM_IDX_IEN     16'hFFFA
// Field positions
`define SPPM_MC_CNTMODE  0
`define SPPM_MC_HALT     1
`define SPPM_MC_CNTIRQ   2
`define SPPM_MC_MULTI    3
`define SPPM_MC_CHSEL    4
`define SPPM_MC_WORD8    6
`define SPPM_ST_SRCSEL   0
`define SPPM_ST_PRESCALER_ENABLE    8
`define SPPM_ST_FSFLAG   12
// Reset values and timing
`define SPPM_RST_PRE     8'h00
`define SPPM_GAP16       5'h11
`define SPPM_GAP8        5'h09
`endif

// ===== sppm_pkg.sv
// Types for the serial port prescaler and multichannel block.
// Assumes the constants header is included by users.
package sppm_pkg;
   typedef enum logic [1:0] {
      SPPM_IDLE = 2'b01,
      SPPM_GAP  = 2'b10
   } sppm_mc_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [17:0] paddr;
      logic [31:0] pwdata;
   } sppm_apb_t;

   typedef struct packed {
      logic        word8;
      logic [1:0]  chSel;
      logic        multi;
      logic        cntIrq;
      logic        cntHalt;
      logic        cntMode;
      logic [7:0]  bufCl;
      logic [7:0]  bufFs;
      logic [7:0]  cntCl;
      logic [7:0]  cntFs;
      logic        prescaler_enable;
      logic        srcSel;
      logic        fsFlag;
      logic        shiftClk;
      logic        fsPhase;
      logic [3:0]  sync;
      sppm_mc_t    mcState;
      logic [1:0]  chanIdx;
      logic [4:0]  gap;
      logic        pinPrev;
      logic [1:0]  irqSts;
      logic [1:0]  irqEn;
      logic        txIrq;
      logic [31:0] rdata;
   } sppm_state_t;
endpackage

// ===== sppm_prescaler.sv
// Shift-clock and frame-sync prescalers, counter mode, multichannel syncs.
// Assumes pins are synchronous to clk and an APB master on the bus.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "sppm_consts.svh"

module sppm_prescaler
   import sppm_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // APB slave
   input  wire sppm_apb_t  apbReq,
   output logic [31:0]     prdata,
   output logic            pready,
   output logic            pslverr,
   // Serial pins and routing
   input  wire logic       shiftClkPin,
   input  wire logic       rcvShiftClkIn,
   input  wire logic       rcvFrameSyncIn,
   output logic            transmitShiftClock,
   output logic            transmitFrameSync,
   output logic            rcvShiftClkInt,
   output logic            rcvFrameSyncInt,
   output logic            rcvShiftClkOut,
   output logic            rcvShiftClkOe,
   output logic            rcvFrameSyncOut,
   output logic            rcvFrameSyncOe,
   // General io zero
   input  wire logic       gioZeroOutReq,
   input  wire logic       gioZeroOeReq,
   output logic            gioZeroOut,
   output logic            gioZeroOe,
   // Events and interrupts
   input  wire logic       txEvent,
   output logic            serialTxIrq,
   output logic            irq
);

   sppm_state_t st_ff;
   sppm_state_t nxt_st;

   logic        wrEn;
   logic        rdSetup;
   logic        hitMc;
   logic        hitCt;
   logic        hitSt;
   logic        hitSts;
   logic        hitClr;
   logic        hitEn;
   logic        mapped;
   logic        pinRise;
   logic        intRise;
   logic        sckTick;
   logic        cntTick;
   logic        fsZero;
   logic        cntZero;
   logic        frameStart;
   logic        prsRise;
   logic [15:0] cnt16;
   logic [4:0]  gapLoad;

   function automatic logic hit(input logic [17:0] a,
                                input logic [15:0] idx);
      hit = (a == {idx, 2'b00});
   endfunction

   always_comb begin
      hitMc  = hit(apbReq.paddr, `SPPM_IDX_MC);
      hitCt  = hit(apbReq.paddr, `SPPM_IDX_CT);
      hitSt  = hit(apbReq.paddr, `SPPM_IDX_ST);
      hitSts = hit(apbReq.paddr, `SPPM_IDX_ISTS);
      hitClr = hit(apbReq.paddr, `SPPM_IDX_ICLR);
      hitEn  = hit(apbReq.paddr, `SPPM_IDX_IEN);
      mapped = hitMc | hitCt | hitSt | hitSts | hitClr | hitEn;
   end

   // Zero wait states: read data is captured in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = apbReq.psel & apbReq.penable & ~mapped;
   assign prdata  = st_ff.rdata;

   always_comb begin
      nxt_st = st_ff;
      wrEn    = apbReq.psel & apbReq.penable & apbReq.pwrite & mapped;
      rdSetup = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;
      pinRise = shiftClkPin & ~st_ff.pinPrev;
      intRise = (st_ff.cntCl == 8'h00) & ~st_ff.shiftClk;
      sckTick = 1'b0;
      cntTick = 1'b0;
      fsZero  = 1'b0;
      cntZero = 1'b0;
      frameStart = 1'b0;
      prsRise = 1'b0;
      cnt16   = {st_ff.cntFs, st_ff.cntCl};
      gapLoad = st_ff.word8 ? `SPPM_GAP8 : `SPPM_GAP16;
      nxt_st.pinPrev = shiftClkPin;

      // Prescaler path, only while not in counter mode
      if (!st_ff.cntMode && st_ff.prescaler_enable) begin
         if (st_ff.cntCl == 8'h00) begin
            nxt_st.cntCl    = st_ff.bufCl;
            nxt_st.shiftClk = ~st_ff.shiftClk;
         end else begin
            nxt_st.cntCl = st_ff.cntCl - 8'h01;
         end
         sckTick = st_ff.srcSel ? pinRise : intRise;
         if (sckTick) begin
            nxt_st.sync = 4'h0;
            if (st_ff.cntFs == 8'h00) begin
               nxt_st.cntFs   = st_ff.bufFs;
               nxt_st.fsPhase = ~st_ff.fsPhase;
               fsZero         = 1'b1;
               frameStart     = ~st_ff.fsPhase;
            end else begin
               nxt_st.cntFs = st_ff.cntFs - 8'h01;
            end
         end
      end

      // Chained 16-bit counter
      if (st_ff.cntMode && !st_ff.cntHalt) begin
         cntTick = st_ff.srcSel ? pinRise : 1'b1;
         if (cntTick) begin
            if (cnt16 == 16'h0000) begin
               {nxt_st.cntFs, nxt_st.cntCl} =
                  {st_ff.bufFs, st_ff.bufCl};
               cntZero = 1'b1;
            end else begin
               {nxt_st.cntFs, nxt_st.cntCl} = cnt16 - 16'h0001;
            end
         end
      end

      // Frame syncs; extra channels only in multichannel mode
      if (frameStart) begin
         nxt_st.sync[0] = 1'b1;
         if (st_ff.multi && st_ff.chSel != 2'b00) begin
            nxt_st.mcState = SPPM_GAP;
            nxt_st.chanIdx = 2'b01;
            nxt_st.gap     = gapLoad;
         end
      end else if (sckTick) begin
         case (st_ff.mcState)
            SPPM_IDLE: begin
               nxt_st.mcState = SPPM_IDLE;
            end
            SPPM_GAP: begin
               if (st_ff.gap == 5'h00) begin
                  nxt_st.sync[st_ff.chanIdx] = 1'b1;
                  if (st_ff.chanIdx == st_ff.chSel) begin
                     nxt_st.mcState = SPPM_IDLE;
                  end else begin
                     nxt_st.chanIdx = st_ff.chanIdx + 2'b01;
                     nxt_st.gap     = gapLoad;
                  end
               end else begin
                  nxt_st.gap = st_ff.gap - 5'h01;
               end
            end
            default: nxt_st.mcState = SPPM_IDLE;
         endcase
      end
      if (!st_ff.multi) begin
         nxt_st.mcState = SPPM_IDLE;
      end

      // Register writes
      if (wrEn && hitMc) begin
         nxt_st.cntMode = apbReq.pwdata[`SPPM_MC_CNTMODE];
         nxt_st.cntHalt = apbReq.pwdata[`SPPM_MC_HALT];
         nxt_st.cntIrq  = apbReq.pwdata[`SPPM_MC_CNTIRQ];
         nxt_st.multi   = apbReq.pwdata[`SPPM_MC_MULTI];
         nxt_st.chSel   = apbReq.pwdata[`SPPM_MC_CHSEL +: 2];
         nxt_st.word8   = apbReq.pwdata[`SPPM_MC_WORD8];
      end
      if (wrEn && hitCt) begin
         nxt_st.bufCl = apbReq.pwdata[7:0];
         nxt_st.bufFs = apbReq.pwdata[15:8];
      end
      if (wrEn && hitSt) begin
         nxt_st.srcSel = apbReq.pwdata[`SPPM_ST_SRCSEL];
         nxt_st.prescaler_enable  = apbReq.pwdata[`SPPM_ST_PRESCALER_ENABLE];
         prsRise = apbReq.pwdata[`SPPM_ST_PRESCALER_ENABLE] & ~st_ff.prescaler_enable;
         if (apbReq.pwdata[`SPPM_ST_FSFLAG]) begin
            nxt_st.fsFlag = 1'b0;
         end
      end
      // Buffers reach the counters when enable rises and at each zero count
      if (prsRise) begin
         nxt_st.cntCl    = st_ff.bufCl;
         nxt_st.cntFs    = st_ff.bufFs;
         nxt_st.shiftClk = 1'b0;
         nxt_st.fsPhase  = 1'b0;
      end
      // Set wins over a clear in the same cycle
      if (fsZero || cntZero) begin
         nxt_st.fsFlag = 1'b1;
      end
      if (wrEn && hitEn) begin
         nxt_st.irqEn = apbReq.pwdata[1:0];
      end
      nxt_st.irqSts = st_ff.irqSts;
      if (wrEn && hitClr) begin
         nxt_st.irqSts = st_ff.irqSts & ~apbReq.pwdata[1:0];
      end
      nxt_st.irqSts = nxt_st.irqSts | {cntZero, fsZero};

      // Transmit interrupt carries either counter zero or transmit events
      nxt_st.txIrq = st_ff.cntIrq ? cntZero : txEvent;

      if (rdSetup) begin
         nxt_st.rdata = 32'h0000_0000;
         if (hitMc) begin
            nxt_st.rdata[6:0] = {st_ff.word8, st_ff.chSel, st_ff.multi,
                                 st_ff.cntIrq, st_ff.cntHalt,
                                 st_ff.cntMode};
         end
         if (hitCt) begin
            nxt_st.rdata[15:0] = {st_ff.cntFs, st_ff.cntCl};
         end
         if (hitSt) begin
            nxt_st.rdata[`SPPM_ST_SRCSEL] = st_ff.srcSel;
            nxt_st.rdata[`SPPM_ST_PRESCALER_ENABLE]  = st_ff.prescaler_enable;
            nxt_st.rdata[`SPPM_ST_FSFLAG] = st_ff.fsFlag;
         end
         if (hitSts) begin
            nxt_st.rdata[1:0] = st_ff.irqSts;
         end
         if (hitEn) begin
            nxt_st.rdata[1:0] = st_ff.irqEn;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff         <= '0;
         st_ff.bufCl   <= `SPPM_RST_PRE;
         st_ff.cntCl   <= `SPPM_RST_PRE;
         st_ff.mcState <= SPPM_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Pin muxing for multichannel mode
   always_comb begin
      transmitShiftClock = st_ff.shiftClk;
      transmitFrameSync  = st_ff.sync[0];
      rcvShiftClkInt  = st_ff.multi ? st_ff.shiftClk : rcvShiftClkIn;
      rcvFrameSyncInt = st_ff.multi ? st_ff.sync[0] : rcvFrameSyncIn;
      rcvShiftClkOut  = st_ff.multi & st_ff.sync[1];
      rcvShiftClkOe   = st_ff.multi;
      rcvFrameSyncOut = st_ff.multi & st_ff.sync[2];
      rcvFrameSyncOe  = st_ff.multi;
      gioZeroOut = st_ff.multi ? st_ff.sync[3] : gioZeroOutReq;
      gioZeroOe  = st_ff.multi | gioZeroOeReq;
      serialTxIrq = st_ff.txIrq;
      irq = |(st_ff.irqSts & st_ff.irqEn);
   end

endmodule // sppm_prescaler

// ===== sppm_props.sv
// Assertions on the ports of the serial port prescaler block.
// Assumes APB writes land at the access edge and shadows track them.
`timescale 1ns/1ps
`include "sppm_consts.svh"
module sppm_props
   import sppm_pkg::*;
(
   // Clock and reset
   input wire logic      clk,
   input wire logic      reset_n,
   // Watched ports
   input wire sppm_apb_t apbReq,
   input wire logic      rcvShiftClkIn,
   input wire logic      transmitShiftClock,
   input wire logic      transmitFrameSync,
   input wire logic      rcvShiftClkInt,
   input wire logic      rcvFrameSyncInt,
   input wire logic      rcvShiftClkOe,
   input wire logic      rcvFrameSyncOe,
   input wire logic      gioZeroOutReq,
   input wire logic      gioZeroOeReq,
   input wire logic      gioZeroOut,
   input wire logic      gioZeroOe,
   input wire logic      txEvent,
   input wire logic      serialTxIrq
);
   logic [3:0] mcSh_ff;
   logic [7:0] clSh_ff;
   logic       prsSh_ff;
   logic [8:0] runLen_ff;
   logic [1:0] seen_ff;
   logic       wr;
   logic [15:0] idx;
   assign wr = apbReq.psel && apbReq.penable && apbReq.pwrite;
   assign idx = apbReq.paddr[17:2];
   // Any write restarts the period check: first period after a load may be odd
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mcSh_ff <= 4'h0;
         clSh_ff <= 8'h00;
         prsSh_ff <= 1'b0;
         runLen_ff <= 9'h000;
         seen_ff <= 2'h0;
      end else begin
         runLen_ff <= $changed(transmitShiftClock) ? 9'h000 : runLen_ff + 9'h001;
         if ($changed(transmitShiftClock) && seen_ff != 2'h2)
            seen_ff <= seen_ff + 2'h1;
         if (wr) begin
            seen_ff <= 2'h0;
            if (idx == `SPPM_IDX_MC) mcSh_ff <= apbReq.pwdata[3:0];
            if (idx == `SPPM_IDX_CT) clSh_ff <= apbReq.pwdata[7:0];
            if (idx == `SPPM_IDX_ST) prsSh_ff <= apbReq.pwdata[`SPPM_ST_PRESCALER_ENABLE];
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_plainIrq;
      !mcSh_ff[2] ##1 !mcSh_ff[2];
   endsequence
   a_multi_oe: assert property (rcvShiftClkOe == mcSh_ff[3])
      else $error("receive clock enable differs from multichannel bit");
   a_route_int: assert property (mcSh_ff[3] |-> rcvFrameSyncOe &&
      rcvShiftClkInt == transmitShiftClock && rcvFrameSyncInt == transmitFrameSync)
      else $error("multichannel routing wrong");
   a_rcv_pass: assert property (!mcSh_ff[3] |-> rcvShiftClkInt == rcvShiftClkIn)
      else $error("receive clock not taken from pin");
   a_gio_pass: assert property (gioZeroOe == (mcSh_ff[3] || gioZeroOeReq) &&
      (mcSh_ff[3] || gioZeroOut == gioZeroOutReq))
      else $error("general io zero ownership wrong");
   a_irq_blocked: assert property (mcSh_ff[2] && !mcSh_ff[0] && txEvent
      |=> !serialTxIrq) else $error("transmit event leaked to interrupt");
   a_irq_plain: assert property (s_plainIrq |-> serialTxIrq == $past(txEvent))
      else $error("transmit interrupt not one cycle after event");
   a_shift_rate: assert property ($changed(transmitShiftClock) &&
      seen_ff == 2'h2 && prsSh_ff && !mcSh_ff[0] |-> runLen_ff == {1'b0, clSh_ff})
      else $error("shift clock half period wrong");
   a_shift_idle: assert property (!prsSh_ff && !$past(prsSh_ff)
      |-> $stable(transmitShiftClock)) else $error("shift clock runs while off");
endmodule // sppm_props
bind sppm_prescaler sppm_props chk (.clk, .reset_n, .apbReq, .rcvShiftClkIn,
   .transmitShiftClock, .transmitFrameSync, .rcvShiftClkInt, .rcvFrameSyncInt,
   .rcvShiftClkOe, .rcvFrameSyncOe, .gioZeroOutReq, .gioZeroOeReq, .gioZeroOut,
   .gioZeroOe, .txEvent, .serialTxIrq);

// ===== tb_top.sv
// Self-checking bench: APB register calls against the prescaler block.
// Assumes zero-wait APB slave and codec model on the serial pins.
`timescale 1ns/1ps
`include "sppm_consts.svh"
module tb_top;
   import sppm_pkg::*;
   logic clk, reset_n, pready, pslverr, tsc, tfs, rci, rfi, rco, rcoe, rfo;
   logic rfoe, gOut, gOe, gOutReq, gOeReq, txEvent, stIrq, irq, pinClk;
   logic rcvDrv, lastErr;
   logic [31:0] prdata, q;
   logic [15:0] riseAt [4];
   logic [15:0] period1;
   logic [7:0]  syncCnt [4];
   sppm_apb_t   apbReq;
   int n_fail, cmp_count, k, n;
   always #5 clk = ~clk;
   sppm_prescaler uut (.clk, .reset_n, .apbReq, .prdata, .pready, .pslverr,
      .shiftClkPin(pinClk), .rcvShiftClkIn(rcoe ? rco : rcvDrv),
      .rcvFrameSyncIn(rfoe ? rfo : ~rcvDrv), .transmitShiftClock(tsc),
      .transmitFrameSync(tfs), .rcvShiftClkInt(rci), .rcvFrameSyncInt(rfi),
      .rcvShiftClkOut(rco), .rcvShiftClkOe(rcoe), .rcvFrameSyncOut(rfo),
      .rcvFrameSyncOe(rfoe), .gioZeroOutReq(gOutReq), .gioZeroOeReq(gOeReq),
      .gioZeroOut(gOut), .gioZeroOe(gOe), .txEvent, .serialTxIrq(stIrq), .irq);
   sppm_codec_model partner (.clk, .reset_n, .syncs({gOut, rfo, rco, tfs}),
      .shiftClkPin(pinClk), .rcvDrive(rcvDrv), .riseAt, .period1, .syncCnt);
   task automatic close_out;
      if (n_fail == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // One transfer, then one idle cycle so no signal is driven twice at an edge
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d);
      int w;
      apbReq <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:{idx, 2'b00}, pwdata:d};
      @(posedge clk);
      apbReq.penable <= 1'b1;
      w = 0;
      do begin
         @(posedge clk);
         w++;
      end while (pready !== 1'b1 && w < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         close_out;
      end
      q = prdata;
      lastErr = pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic pulse(input logic e);
      txEvent <= 1'b1;
      @(posedge clk);
      txEvent <= 1'b0;
      @(posedge clk);
      chk(stIrq, e);
   endtask
   task automatic countIrq(output int c);
      c = 0;
      repeat (40) begin
         @(posedge clk);
         if (stIrq === 1'b1) c++;
      end
   endtask
   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      apbReq = '0;
      txEvent = 1'b0;
      gOutReq = 1'b1;
      gOeReq = 1'b0;
      n_fail = 0;
      cmp_count = 0;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, `SPPM_IDX_MC, 32'h0);
      chk(q[3:0], 4'h0);
      apb(1'b0, `SPPM_IDX_CT, 32'h0);
      chk(q[7:0], `SPPM_RST_PRE);
      apb(1'b0, 16'h0123, 32'h0);
      chk(lastErr, 1'b1);
      pulse(1'b1);
      chk(gOut, 1'b1);
      chk(gOe, 1'b0);
      // Four channels at the smallest legal frame prescale
      apb(1'b1, `SPPM_IDX_CT, 32'h0000_2302);
      apb(1'b1, `SPPM_IDX_MC, 32'h0000_0038);
      apb(1'b1, `SPPM_IDX_ST, 32'h0000_0100);
      // The pass-through level counted one rise before multichannel began
      n = syncCnt[3];
      k = 0;
      while (syncCnt[3] < n + 2 && k < 5000) begin
         @(posedge clk);
         k++;
      end
      if (k == 5000) begin
         n_fail++;
         close_out;
      end
      chk(period1, 16'd432);
      for (k = 1; k < 4; k++) chk(riseAt[k] - riseAt[k-1], 16'd108);
      chk(gOe, 1'b1);
      apb(1'b0, `SPPM_IDX_ST, 32'h0);
      chk(q[`SPPM_ST_FSFLAG], 1'b1);
      apb(1'b1, `SPPM_IDX_ST, 32'h0);
      apb(1'b1, `SPPM_IDX_ST, 32'h1000);
      apb(1'b0, `SPPM_IDX_ST, 32'h0);
      chk(q[`SPPM_ST_FSFLAG], 1'b0);
      apb(1'b0, `SPPM_IDX_ISTS, 32'h0);
      chk(q[0], 1'b1);
      chk(irq, 1'b0);
      apb(1'b1, `SPPM_IDX_IEN, 32'h1);
      chk(irq, 1'b1);
      apb(1'b1, `SPPM_IDX_ICLR, 32'h1);
      chk(irq, 1'b0);
      // Counter mode from the core clock, start value 3
      apb(1'b1, `SPPM_IDX_CT, 32'h0000_0003);
      apb(1'b1, `SPPM_IDX_ST, 32'h0000_0100);
      apb(1'b1, `SPPM_IDX_MC, 32'h0000_0005);
      repeat (8) @(posedge clk);
      countIrq(n);
      chk(n, 32'd10);
      apb(1'b1, `SPPM_IDX_MC, 32'h0000_0007);
      countIrq(n);
      chk(n, 32'd0);
      apb(1'b1, `SPPM_IDX_MC, 32'h0000_0004);
      pulse(1'b0);
      // Counter mode from the pin clock: one tick per pin rise, two cycles
      apb(1'b1, `SPPM_IDX_ST, 32'h0000_0101);
      apb(1'b1, `SPPM_IDX_MC, 32'h0000_0005);
      repeat (16) @(posedge clk);
      countIrq(n);
      chk(n, 32'h0000_0005);
      close_out;
   end
endmodule // tb_top
